/* verilog/rtw_timers.sv */
/*
 * Third reload timer and low-frequency wake-up timer with card detection
 * sequencing, reached as an APB slave with one wait state.
 * Assumes txEnd and cardPresent come from logic on ref_clk; lfoClk is a
 * slow oscillator sampled as an asynchronous level.
 */
`include "rtw_params.svh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Start event loads third timer from upper and lower reload bytes
// [R2] Reload writes do not disturb a running count; used at next start
// [R3] Live third timer count readable as upper and lower bytes
// [R4] Software must not read the live count during frame reception
// [R5] Wake-up timer reactivates system and can launch card detection
// [R6] Control bit 7 reads back whether wake-up timer runs
// [R7] Running bit changes only in a write with bit 6 set; code also clears it at an underflow with bits 3 and 4 clear
// [R8] Trim enable: each wake-up underflow triggers oscillator trimming
// [R9] Software configures a trim timer; not the third one with detection
// [R10] Detection enable: each wake-up underflow starts card detection; code ignores one that falls inside an open field window
// [R11] Card found raises interrupt request; device stays active
// [R12] No card found enters power-down when enabled
// [R13] During card detection wake-up timer restarts with no gap
// [R14] Third timer sets how long the RF field stays on
// [R15] Bit 3 reloads after zero; otherwise count to zero and stop
// [R16] Each wake-up underflow sets its interrupt flag
// [R17] Bit 2 set: wake-up underflow wakes device
// [R18] Software sets bit 2 for power-down after no card, else clears
// [R19] Clock field selects oscillator undivided, /8, /16 or /32
// [R20] Start select 01 starts third timer at end of transmission
// [R21] Each tick decrements; underflow signalled when count passes zero
module rtw_timers (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus
    input wire rtw_pkg::rtw_apb_req_t apbReq,
    output rtw_pkg::rtw_apb_rsp_t apbRsp,
    // Radio and oscillator side
    input wire logic lfoClk,
    input wire logic txEnd,
    input wire logic cardPresent,
    // System events
    output logic rfFieldOn,
    output logic wakeRequest,
    output logic trimStart,
    output logic powerDownReq,
    output logic wakeIrq,
    output logic cardIrq
);

    rtw_pkg::rtw_state_t st_q;
    rtw_pkg::rtw_state_t st_d;
    logic lfoEdge;
    logic t4Tick;
    logic uf4;
    logic uf3;
    logic t3StartTx;
    logic commit;
    logic [7:0] idx;
    logic mapped;
    logic [7:0] rdByte;

    function automatic logic divTick(input logic [4:0] d,
                                     input logic [1:0] sel);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'h0: r = 1'b1;
            2'h1: r = (d[2:0] == `RTW_DIV8_END);
            2'h2: r = (d[3:0] == `RTW_DIV16_END);
            2'h3: r = (d == `RTW_DIV32_END);
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register read decode
    always_comb begin
        idx = apbReq.paddr[9:2];
        mapped = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr[31:10] == 22'h0);
        rdByte = `RTW_RST_BYTE;
        if (mapped) begin
            unique case (idx)
                `RTW_IDX_T3_CTRL: begin
                    rdByte[`RTW_T3_START_HI:`RTW_T3_START_LO] = st_q.t3StartSel;
                end
                `RTW_IDX_T3_RLD_UP: rdByte = st_q.t3Reload[15:8];
                `RTW_IDX_T3_RLD_LO: rdByte = st_q.t3Reload[7:0];
                `RTW_IDX_T3_CNT_UP: rdByte = st_q.t3Count[15:8]; // R3
                `RTW_IDX_T3_CNT_LO: rdByte = st_q.t3Count[7:0]; // R3
                `RTW_IDX_T4_CTRL: begin
                    rdByte[`RTW_T4_ACTIVE_BIT] = st_q.t4Run; // R6
                    rdByte[`RTW_T4_TRIM_BIT] = st_q.t4Trim;
                    rdByte[`RTW_T4_LOW_POWER_CARD_DETECTION_BIT] = st_q.t4Lpcd;
                    rdByte[`RTW_T4_RELOAD_BIT] = st_q.t4Restart;
                    rdByte[`RTW_T4_WAKE_BIT] = st_q.t4Wake;
                    rdByte[`RTW_T4_CLK_HI:`RTW_T4_CLK_LO] = st_q.wakeup_clock_select;
                end
                `RTW_IDX_T4_RLD_UP: rdByte = st_q.t4Reload[15:8];
                `RTW_IDX_T4_RLD_LO: rdByte = st_q.t4Reload[7:0];
                `RTW_IDX_T4_CNT_UP: rdByte = st_q.t4Count[15:8];
                `RTW_IDX_T4_CNT_LO: rdByte = st_q.t4Count[7:0];
                `RTW_IDX_STATUS: begin
                    rdByte[`RTW_ST_WAKE_BIT] = st_q.wakeFlag;
                    rdByte[`RTW_ST_CARD_BIT] = st_q.cardFlag;
                end
                default: mapped = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.wakePulse = 1'b0;
        st_d.trimPulse = 1'b0;
        st_d.pdPulse = 1'b0;
        st_d.rsp.pready = 1'b0;
        commit = apbReq.psel && apbReq.penable && st_q.rsp.pready;

        // Oscillator synchroniser and prescaler
        st_d.lfoMeta = lfoClk;
        st_d.lfoSync = st_q.lfoMeta;
        st_d.lfoPrev = st_q.lfoSync;
        lfoEdge = st_q.lfoSync && !st_q.lfoPrev;
        if (lfoEdge) begin
            st_d.div = st_q.div + 5'h1;
        end
        t4Tick = lfoEdge && divTick(st_q.div, st_q.wakeup_clock_select); // R19

        // Bus answer one cycle into the access phase
        if (apbReq.psel && apbReq.penable && !st_q.rsp.pready) begin
            st_d.rsp.pready = 1'b1;
            st_d.rsp.pslverr = !mapped;
            st_d.rsp.prdata = {24'h0, rdByte};
        end

        // Configuration writes and flag clears
        if (commit && apbReq.pwrite && mapped) begin
            unique case (idx)
                `RTW_IDX_T3_CTRL: begin
                    st_d.t3StartSel =
                        apbReq.pwdata[`RTW_T3_START_HI:`RTW_T3_START_LO];
                end
                `RTW_IDX_T3_RLD_UP: st_d.t3Reload[15:8] = apbReq.pwdata[7:0];
                `RTW_IDX_T3_RLD_LO: st_d.t3Reload[7:0] = apbReq.pwdata[7:0];
                `RTW_IDX_T4_CTRL: begin
                    st_d.t4Trim = apbReq.pwdata[`RTW_T4_TRIM_BIT];
                    st_d.t4Lpcd = apbReq.pwdata[`RTW_T4_LOW_POWER_CARD_DETECTION_BIT];
                    st_d.t4Restart = apbReq.pwdata[`RTW_T4_RELOAD_BIT];
                    st_d.t4Wake = apbReq.pwdata[`RTW_T4_WAKE_BIT];
                    st_d.wakeup_clock_select = apbReq.pwdata[`RTW_T4_CLK_HI:`RTW_T4_CLK_LO];
                end
                `RTW_IDX_T4_RLD_UP: st_d.t4Reload[15:8] = apbReq.pwdata[7:0];
                `RTW_IDX_T4_RLD_LO: st_d.t4Reload[7:0] = apbReq.pwdata[7:0];
                `RTW_IDX_STATUS: begin
                    if (apbReq.pwdata[`RTW_ST_WAKE_BIT]) begin
                        st_d.wakeFlag = 1'b0;
                    end
                    if (apbReq.pwdata[`RTW_ST_CARD_BIT]) begin
                        st_d.cardFlag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Wake-up timer
        uf4 = 1'b0;
        if (st_q.t4Run && t4Tick) begin
            if (st_q.t4Count == `RTW_RST_WORD) begin
                uf4 = 1'b1; // R21
                if (st_q.t4Restart || st_q.t4Lpcd) begin
                    st_d.t4Count = st_q.t4Reload; // R15 R13
                end else begin
                    st_d.t4Run = 1'b0; // R15
                end
            end else begin
                st_d.t4Count = st_q.t4Count - 16'h1; // R21
            end
        end
        if (uf4) begin
            st_d.wakeFlag = 1'b1; // R16
            st_d.wakePulse = st_q.t4Wake; // R17 R5
            st_d.trimPulse = st_q.t4Trim; // R8
        end

        // Third timer countdown
        uf3 = 1'b0;
        if (st_q.t3Run) begin
            if (st_q.t3Count == `RTW_RST_WORD) begin
                uf3 = 1'b1; // R21
                st_d.t3Run = 1'b0;
            end else begin
                st_d.t3Count = st_q.t3Count - 16'h1; // R21
            end
        end

        // Start events; reload bytes are sampled only here
        t3StartTx = txEnd && (st_q.t3StartSel == `RTW_T3_START_TXEND); // R20
        if (uf4 && st_q.t4Lpcd && st_q.lp == rtw_pkg::LP_IDLE) begin
            st_d.t3Count = st_q.t3Reload; // R1 R10
            st_d.t3Run = 1'b1;
            st_d.lp = rtw_pkg::LP_FIELD;
            st_d.rfOn = 1'b1; // R14
        end else if (t3StartTx && st_q.lp == rtw_pkg::LP_IDLE) begin
            st_d.t3Count = st_q.t3Reload; // R1 R2
            st_d.t3Run = 1'b1;
        end

        // Card detection outcome at end of field window
        unique case (st_q.lp)
            rtw_pkg::LP_IDLE: ;
            rtw_pkg::LP_FIELD: begin
                if (uf3) begin
                    st_d.lp = rtw_pkg::LP_IDLE;
                    st_d.rfOn = 1'b0; // R14
                    if (cardPresent) begin
                        st_d.cardFlag = 1'b1; // R11
                    end else begin
                        st_d.pdPulse = st_q.t4Wake; // R12
                    end
                end
            end
        endcase

        // Running bit, qualified by bit 6
        if (commit && apbReq.pwrite && mapped && idx == `RTW_IDX_T4_CTRL &&
            apbReq.pwdata[`RTW_T4_QUAL_BIT]) begin // R7
            st_d.t4Run = apbReq.pwdata[`RTW_T4_ACTIVE_BIT];
            if (apbReq.pwdata[`RTW_T4_ACTIVE_BIT] && !st_q.t4Run) begin
                st_d.t4Count = st_q.t4Reload;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign apbRsp = st_q.rsp;
    assign rfFieldOn = st_q.rfOn;
    assign wakeRequest = st_q.wakePulse;
    assign trimStart = st_q.trimPulse;
    assign powerDownReq = st_q.pdPulse;
    assign wakeIrq = st_q.wakeFlag;
    assign cardIrq = st_q.cardFlag;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_lpcdStart;
        uf4 && st_q.t4Lpcd && st_q.lp == rtw_pkg::LP_IDLE;
    endsequence

    sequence s_fieldEnd;
        uf3 && st_q.lp == rtw_pkg::LP_FIELD;
    endsequence

    sequence s_ctrlWrite;
        commit && apbReq.pwrite && mapped && idx == `RTW_IDX_T4_CTRL;
    endsequence

    a_t3_start_load: assert property ( // R1
        t3StartTx && !uf4 && st_q.lp == rtw_pkg::LP_IDLE
        |=> st_q.t3Run && st_q.t3Count == $past(st_q.t3Reload))
        else $error("third timer did not load reload value");

    a_tx_refused: assert property ( // R20
        txEnd && st_q.t3StartSel != `RTW_T3_START_TXEND && !uf4 &&
        !st_q.t3Run |=> !st_q.t3Run)
        else $error("third timer started without its start select");

    a_field_idle_off: assert property ( // R14
        st_q.lp == rtw_pkg::LP_IDLE |-> !rfFieldOn)
        else $error("field on outside detection window");

    a_reload_no_disturb: assert property ( // R2
        st_q.t3Run && st_q.t3Count != 16'h0 && !t3StartTx && !uf4
        |=> st_q.t3Count == $past(st_q.t3Count) - 16'h1)
        else $error("running third timer count disturbed");

    a_count_readback: assert property ( // R3
        apbReq.psel && apbReq.penable && !st_q.rsp.pready &&
        !apbReq.pwrite && mapped && idx == `RTW_IDX_T3_CNT_UP
        |=> st_q.rsp.prdata[7:0] == $past(st_q.t3Count[15:8]))
        else $error("count upper byte read mismatch");

    a_active_readback: assert property ( // R6
        apbReq.psel && apbReq.penable && !st_q.rsp.pready &&
        mapped && idx == `RTW_IDX_T4_CTRL
        |=> st_q.rsp.prdata[`RTW_T4_ACTIVE_BIT] == $past(st_q.t4Run))
        else $error("active bit read mismatch");

    a_run_qualified: assert property ( // R7
        s_ctrlWrite and (!apbReq.pwdata[`RTW_T4_QUAL_BIT] && !uf4)
        |=> $stable(st_q.t4Run))
        else $error("running bit changed without qualifier");

    a_trim_trigger: assert property ( // R8
        uf4 && st_q.t4Trim |=> trimStart)
        else $error("trim not triggered on underflow");

    a_low_power_card_detection_launch: assert property ( // R10 R14 R5
        s_lpcdStart |=> rfFieldOn && st_q.t3Run ##0 rfFieldOn [*1])
        else $error("card detection not launched");

    a_card_irq: assert property ( // R11
        s_fieldEnd and cardPresent |=> cardIrq && !rfFieldOn)
        else $error("card found without interrupt");

    a_no_card_pd: assert property ( // R12
        s_fieldEnd and (!cardPresent && st_q.t4Wake) |=> powerDownReq)
        else $error("no power-down after empty detection");

    a_no_gap: assert property ( // R13 R15
        uf4 && (st_q.t4Lpcd || st_q.t4Restart) && !commit
        |=> st_q.t4Run && st_q.t4Count == $past(st_q.t4Reload))
        else $error("wake-up timer did not restart");

    a_oneshot_stop: assert property ( // R15
        uf4 && !st_q.t4Lpcd && !st_q.t4Restart && !commit |=> !st_q.t4Run)
        else $error("one-shot wake-up timer kept running");

    a_irq_flag: assert property ( // R16
        uf4 |=> wakeIrq)
        else $error("underflow flag not set");

    a_auto_wake: assert property ( // R17
        uf4 |=> wakeRequest == $past(st_q.t4Wake))
        else $error("wake request mismatch");

    a_clk_div8: assert property ( // R19
        t4Tick && st_q.wakeup_clock_select == 2'h1 |-> st_q.div[2:0] == `RTW_DIV8_END)
        else $error("divide by eight tick misplaced");

endmodule

/* verilog/rtw_params.svh */
/*
 * Constants of the reload timer and wake-up timer block: register indices,
 * control field positions, prescaler end counts and reset values.
 * Assumes inclusion by rtw_timers.sv and by the bench; definitions only.
 */
`ifndef RTW_PARAMS_SVH
`define RTW_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Register indices (byte address is four times the index)
`define RTW_IDX_T3_CTRL     8'h1E
`define RTW_IDX_T3_RLD_UP   8'h1F
`define RTW_IDX_T3_RLD_LO   8'h20
`define RTW_IDX_T3_CNT_UP   8'h21
`define RTW_IDX_T3_CNT_LO   8'h22
`define RTW_IDX_T4_CTRL     8'h23
`define RTW_IDX_T4_RLD_UP   8'h24
`define RTW_IDX_T4_RLD_LO   8'h25
`define RTW_IDX_T4_CNT_UP   8'h26
`define RTW_IDX_T4_CNT_LO   8'h27
`define RTW_IDX_STATUS      8'h2F

////////////////////////////////////////////////////////////////////////////
// Wake-up control fields
`define RTW_T4_ACTIVE_BIT   7
`define RTW_T4_QUAL_BIT     6
`define RTW_T4_TRIM_BIT     5
`define RTW_T4_LOW_POWER_CARD_DETECTION_BIT     4
`define RTW_T4_RELOAD_BIT   3
`define RTW_T4_WAKE_BIT     2
`define RTW_T4_CLK_HI       1
`define RTW_T4_CLK_LO       0

// Third timer control: start select field
`define RTW_T3_START_HI     5
`define RTW_T3_START_LO     4
`define RTW_T3_START_TXEND  2'h1

// Status fields, write one to clear
`define RTW_ST_WAKE_BIT     0
`define RTW_ST_CARD_BIT     1

////////////////////////////////////////////////////////////////////////////
// Prescaler end counts
`define RTW_DIV8_END        3'h7
`define RTW_DIV16_END       4'hF
`define RTW_DIV32_END       5'h1F

// Reset values
`define RTW_RST_BYTE        8'h00
`define RTW_RST_WORD        16'h0000
`define RTW_RST_BUS         32'h0000_0000

`endif

/* verilog/rtw_pkg.sv */
/*
 * Types of the reload timer and wake-up timer block.
 * Assumes rtw_params.svh supplies the numeric constants.
 */
package rtw_pkg;

    typedef enum logic [0:0] {
        LP_IDLE,
        LP_FIELD
    } rtw_low_power_card_detection_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } rtw_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rtw_apb_rsp_t;

    typedef struct packed {
        logic [15:0] t3Reload;
        logic [15:0] t3Count;
        logic t3Run;
        logic [1:0] t3StartSel;
        logic [15:0] t4Reload;
        logic [15:0] t4Count;
        logic t4Run;
        logic t4Trim;
        logic t4Lpcd;
        logic t4Restart;
        logic t4Wake;
        logic [1:0] wakeup_clock_select;
        logic [4:0] div;
        logic lfoMeta;
        logic lfoSync;
        logic lfoPrev;
        logic wakeFlag;
        logic cardFlag;
        rtw_low_power_card_detection_t lp;
        logic rfOn;
        logic wakePulse;
        logic trimPulse;
        logic pdPulse;
        rtw_apb_rsp_t rsp;
    } rtw_state_t;

endpackage

/* bench/tb_top.sv */
/*
 * Self-checking bench of the reload timer and wake-up timer block: APB
 * register access, third timer start and reload, wake-up prescaler,
 * restart and card detection window.
 * Assumes rtw_pkg, rtw_params.svh and rtw_timers are compiled alongside.
 */
`include "rtw_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // Signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic lfoClk = 1'b0;
    logic txEnd = 1'b0;
    logic cardPresent = 1'b0;
    rtw_pkg::rtw_apb_req_t apbReq = '0;
    rtw_pkg::rtw_apb_rsp_t apbRsp;
    logic rfFieldOn, wakeRequest, trimStart, powerDownReq, wakeIrq, cardIrq;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    int wakeCnt = 0;
    int trimCnt = 0;
    int pdCnt = 0;
    logic [31:0] d;
    logic err;
    int a, b, n;
    int divs [4] = '{1, 8, 16, 32};

    rtw_timers i_rtw_timers (
        .ref_clk(ref_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
        .lfoClk(lfoClk), .txEnd(txEnd), .cardPresent(cardPresent),
        .rfFieldOn(rfFieldOn), .wakeRequest(wakeRequest),
        .trimStart(trimStart), .powerDownReq(powerDownReq),
        .wakeIrq(wakeIrq), .cardIrq(cardIrq));

    always #20 ref_clk = ~ref_clk;

    // Slow oscillator, period of 8 ref_clk cycles, driven on the edge
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc % 4 == 0) begin
            lfoClk <= ~lfoClk;
        end
        wakeCnt += (wakeRequest === 1'b1);
        trimCnt += (trimStart === 1'b1);
        pdCnt += (powerDownReq === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge ref_clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= w;
        apbReq.paddr <= {22'h0, idx, 2'h0};
        apbReq.pwdata <= wd;
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, wd, r, e);
    endtask

    task automatic pulse_tx;
        @(posedge ref_clk);
        txEnd <= 1'b1;
        @(posedge ref_clk);
        txEnd <= 1'b0;
    endtask

    task automatic wait_wake(output int c);
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wakeRequest !== 1'b1 && k < 3000);
        if (k >= 3000)
            chk(32'h0000_0002, 32'h0000_0000);
        c = int'($time / 40);
    endtask

    // Cycles for which the field stays on in the next window
    task automatic field(output int w);
        int k;
        k = 0;
        w = 0;
        while (rfFieldOn !== 1'b1 && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        while (rfFieldOn === 1'b1 && w < 200) begin
            @(posedge ref_clk);
            w++;
        end
        repeat (3) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = `RTW_IDX_T3_RLD_UP; i <= `RTW_IDX_T4_CTRL; i++) begin
            apb(1'b0, 8'(i), 32'h0, d, err);
            chk(d, 32'h0000_0000);
        end
        apb(1'b0, 8'h3F, 32'h0, d, err);
        chk({31'h0, err}, 32'h0000_0001);
        chk(d, 32'h0000_0000);
        wr(`RTW_IDX_T3_CNT_UP, 32'h0000_00FF);
        apb(1'b0, `RTW_IDX_T3_CNT_UP, 32'h0, d, err);
        chk(d, 32'h0000_0000);
        $display("test access done");

        wr(`RTW_IDX_T3_RLD_UP, 32'h0000_0012);
        wr(`RTW_IDX_T3_RLD_LO, 32'h0000_0034);
        apb(1'b0, `RTW_IDX_T3_RLD_LO, 32'h0, d, err);
        chk(d, 32'h0000_0034);
        pulse_tx();
        apb(1'b0, `RTW_IDX_T3_CNT_UP, 32'h0, d, err);
        chk(d, 32'h0000_0000);
        wr(`RTW_IDX_T3_CTRL, 32'h0000_0010);
        pulse_tx();
        apb(1'b0, `RTW_IDX_T3_CNT_UP, 32'h0, d, err);
        chk(d, 32'h0000_0012);
        wr(`RTW_IDX_T3_RLD_UP, 32'h0000_0056);
        apb(1'b0, `RTW_IDX_T3_CNT_UP, 32'h0, d, err);
        chk(d, 32'h0000_0012);
        repeat (5000) @(posedge ref_clk);
        apb(1'b0, `RTW_IDX_T3_CNT_UP, 32'h0, d, err);
        chk(d, 32'h0000_0000);
        pulse_tx();
        apb(1'b0, `RTW_IDX_T3_CNT_UP, 32'h0, d, err);
        chk(d, 32'h0000_0056);
        $display("test third timer done");

        wr(`RTW_IDX_T4_CTRL, 32'h0000_0080);
        apb(1'b0, `RTW_IDX_T4_CTRL, 32'h0, d, err);
        chk(d & 32'h80, 32'h0000_0000);
        wr(`RTW_IDX_T4_RLD_UP, 32'h0000_0000);
        wr(`RTW_IDX_T4_RLD_LO, 32'h0000_0003);
        wakeCnt = 0;
        trimCnt = 0;
        for (int s = 0; s < 4; s++) begin
            wr(`RTW_IDX_T4_CTRL, 32'h0000_00EC | s);
            apb(1'b0, `RTW_IDX_T4_CTRL, 32'h0, d, err);
            chk(d & 32'h80, 32'h0000_0080);
            wait_wake(a);
            wait_wake(b);
            chk(b - a, 32 * divs[s]);
            wr(`RTW_IDX_T4_CTRL, 32'h0000_0040);
        end
        repeat (3) @(posedge ref_clk);
        chk(trimCnt, wakeCnt);
        chk({31'h0, wakeIrq}, 32'h0000_0001);
        wr(`RTW_IDX_STATUS, 32'h0000_0001);
        repeat (300) @(posedge ref_clk);
        chk({31'h0, wakeIrq}, 32'h0000_0000);
        wakeCnt = 0;
        wr(`RTW_IDX_T4_CTRL, 32'h0000_00C4);
        repeat (400) @(posedge ref_clk);
        chk(wakeCnt, 32'h0000_0001);
        wr(`RTW_IDX_T4_CTRL, 32'h0000_0040);
        $display("test wake-up timer done");

        wr(`RTW_IDX_T3_RLD_UP, 32'h0000_0000);
        wr(`RTW_IDX_T3_RLD_LO, 32'h0000_0010);
        pdCnt = 0;
        wr(`RTW_IDX_T4_CTRL, 32'h0000_00DC);
        field(n);
        chk(n, 32'h0000_0011);
        chk(pdCnt, 32'h0000_0001);
        chk({31'h0, cardIrq}, 32'h0000_0000);
        cardPresent <= 1'b1;
        field(n);
        chk({31'h0, cardIrq}, 32'h0000_0001);
        wait_wake(a);
        wait_wake(b);
        chk(b - a, 32'h0000_0020);
        wr(`RTW_IDX_T4_CTRL, 32'h0000_0040);
        $display("test card detection done");
        end_sim();
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end
endmodule
